// *** design/halfword_signed_load_store.sv ***
// Execution datapath for halfword and signed byte/halfword transfers.
// Assumes the core supplies register operands on issue and the memory
// system answers read data and abort in the same cycle as the request.
//
// Behaviour
// - Transfer executes only when the condition evaluates true.
// - Immediate offset is instruction bits 11:8 then bits 3:0.
// - Up bit set adds offset to base, clear subtracts it.
// - Pre bit uses modified base as address, else unmodified base.
// - Pre-indexed writes modified base back only when write-back bit set.
// - Post-indexed always writes modified base back.
// - Signed clear, half set gives unsigned halfword load or store.
// - Signed set loads byte (half clear) or halfword (half set).
// - Signed byte fills bits 31 to 8 with byte bit 7.
// - Signed halfword fills bits 31 to 16 with halfword bit 15.
// - Unsigned halfword clears upper 16 bits.
// - Endian input selects little or big lane mapping.
// - Little-endian byte lanes rise with address.
// - Little-endian halfword: low half at bit1 clear, high otherwise.
// - Big-endian byte lanes fall with address from bits 31..24.
// - Big-endian halfword: high half at bit1 clear, low otherwise.
// - Store repeats low 16 source bits on both bus halves.
// - Abort leaves base at original value and destination untouched.
// - Each transfer completes in one cycle, back to back.
`timescale 1ns/1ps

module halfword_signed_load_store
   import hw_ls_pkg::*;
(
   input  wire logic              core_clk_i,
   input  wire logic              resetn_i,
   input  wire logic              issue_i,
   input  wire logic [DATA_W-1:0] instr_i,
   input  wire logic              cond_pass_i,
   input  wire logic [DATA_W-1:0] base_val_i,
   input  wire logic [DATA_W-1:0] index_val_i,
   input  wire logic [DATA_W-1:0] store_val_i,
   input  wire logic              big_endian_select_i,
   input  wire logic [DATA_W-1:0] mem_rdata_i,
   input  wire logic              mem_abort_i,
   output logic                   mem_req_o,
   output logic                   mem_write_o,
   output logic [DATA_W-1:0]      mem_addr_o,
   output logic [DATA_W-1:0]      mem_wdata_o,
   output logic                   dest_we_o,
   output logic [DATA_W-1:0]      dest_data_o,
   output logic                   base_we_o,
   output logic [DATA_W-1:0]      base_data_o,
   output logic                   abort_trap_o
);

   // Pick the loaded value from the bus lanes and extend it
   function automatic logic [DATA_W-1:0] load_extract(
      input logic [DATA_W-1:0] word,
      input logic [1:0]        addr_lo,
      input logic              be,
      input xfer_kind_type     kind
   );
      logic [1:0]        lane;
      logic [BYTE_W-1:0] byte_v;
      logic [HALF_W-1:0] half_v;
      logic              upper;
      lane   = be ? ~addr_lo : addr_lo;
      byte_v = word[lane*BYTE_W +: BYTE_W];
      upper  = be ? ~addr_lo[1] : addr_lo[1];
      half_v = upper ? word[DATA_W-1:HALF_W] : word[HALF_W-1:0];
      case (kind)
         KIND_LOAD_SBYTE: load_extract = {{(DATA_W-BYTE_W){byte_v[BYTE_W-1]}}, byte_v};
         KIND_LOAD_SHALF: load_extract = {{(DATA_W-HALF_W){half_v[HALF_W-1]}}, half_v};
         KIND_LOAD_UHALF: load_extract = {{(DATA_W-HALF_W){1'b0}}, half_v};
         default:         load_extract = ZERO_WORD;
      endcase
   endfunction

   // Endian pin synchroniser and its settled value
   logic [SYNC_STAGES-1:0] be_sync_q;
   logic                   be_q;

   // Issue decode
   logic          is_class;
   logic          go;
   logic          f_pre;
   logic          f_up;
   logic          f_wb;
   logic          f_load;
   logic          f_signed;
   logic          f_half;
   logic [DATA_W-1:0] offset;
   logic [DATA_W-1:0] modified;
   xfer_kind_type kind_d;

   // Request stage
   logic              req_q;
   logic              write_q;
   logic [DATA_W-1:0] addr_q;
   logic [DATA_W-1:0] wdata_q;
   xfer_kind_type     kind_q;
   logic              xfer_be_q;
   logic              wb_q;
   logic [DATA_W-1:0] wb_val_q;

   // Completion stage
   logic              dest_we_q;
   logic [DATA_W-1:0] dest_data_q;
   logic              base_we_q;
   logic [DATA_W-1:0] base_data_q;
   logic              abort_q;

   // Three-stage sync, change taken when last two agree
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         be_sync_q <= '0;
      end else begin
         be_sync_q <= {be_sync_q[SYNC_STAGES-2:0], big_endian_select_i};
      end
   end

   // Settled endian level
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         be_q <= BE_RESET;
      end else if (be_sync_q[2] == be_sync_q[1]) begin
         be_q <= be_sync_q[2];
      end
   end

   // Field decode
   assign f_pre    = instr_i[BIT_PRE];
   assign f_up     = instr_i[BIT_UP];
   assign f_wb     = instr_i[BIT_WB];
   assign f_load   = instr_i[BIT_LOAD];
   assign f_signed = instr_i[BIT_SIGNED];
   assign f_half   = instr_i[BIT_HALF];
   assign is_class = (instr_i[CLASS_MSB:CLASS_LSB] == CLASS_CODE) &&
                     instr_i[BIT_MARK_HI] && instr_i[BIT_MARK_LO] &&
                     (f_signed || f_half);

   // Only a true condition lets the transfer run
   assign go = issue_i && cond_pass_i && is_class && (f_load || !f_signed);

   // Transfer kind
   always_comb begin
      kind_d = KIND_NONE;
      if (!f_signed && f_half) begin
         kind_d = f_load ? KIND_LOAD_UHALF : KIND_STORE_HALF;
      end else if (f_signed && f_load) begin
         kind_d = f_half ? KIND_LOAD_SHALF : KIND_LOAD_SBYTE;
      end
   end

   // Offset source: split immediate or index register
   assign offset = instr_i[BIT_IMM] ?
                   {OFFSET_PAD, instr_i[IMM_HI_MSB:IMM_HI_LSB], instr_i[IMM_LO_MSB:IMM_LO_LSB]}
                   : index_val_i;

   // Base plus or minus offset
   assign modified = f_up ? base_val_i + offset : base_val_i - offset;

   // Request stage registers
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         req_q     <= 1'b0;
         write_q   <= 1'b0;
         addr_q    <= ZERO_WORD;
         wdata_q   <= ZERO_WORD;
         kind_q    <= KIND_NONE;
         xfer_be_q <= BE_RESET;
         wb_q      <= 1'b0;
         wb_val_q  <= ZERO_WORD;
      end else begin
         req_q <= go;
         if (go) begin
            write_q   <= !f_load;
            addr_q    <= f_pre ? modified : base_val_i;
            wdata_q   <= {store_val_i[HALF_W-1:0], store_val_i[HALF_W-1:0]};
            kind_q    <= kind_d;
            xfer_be_q <= be_q;
            wb_q      <= f_pre ? f_wb : 1'b1;
            wb_val_q  <= modified;
         end
      end
   end

   // Completion: results or abort restore
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         dest_we_q   <= 1'b0;
         dest_data_q <= ZERO_WORD;
         base_we_q   <= 1'b0;
         base_data_q <= ZERO_WORD;
         abort_q     <= 1'b0;
      end else begin
         dest_we_q <= req_q && !write_q && !mem_abort_i;
         base_we_q <= req_q && wb_q && !mem_abort_i;
         abort_q   <= req_q && mem_abort_i;
         if (req_q && !write_q) begin
            dest_data_q <= load_extract(mem_rdata_i, addr_q[1:0], xfer_be_q, kind_q);
         end
         if (req_q && wb_q) begin
            base_data_q <= wb_val_q;
         end
      end
   end

   // Outputs
   assign mem_req_o    = req_q;
   assign mem_write_o  = write_q;
   assign mem_addr_o   = addr_q;
   assign mem_wdata_o  = wdata_q;
   assign dest_we_o    = dest_we_q;
   assign dest_data_o  = dest_data_q;
   assign base_we_o    = base_we_q;
   assign base_data_o  = base_data_q;
   assign abort_trap_o = abort_q;

   // Checks
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!resetn_i);

   // False condition issues nothing
   property p_cond_gate;
      (issue_i && !cond_pass_i) |=> !mem_req_o;
   endproperty
   a_cond_gate: assert property (p_cond_gate) else $error("request after failed condition");

   // Immediate pre-indexed up address
   property p_imm_up;
      (go && instr_i[BIT_IMM] && f_pre && f_up) |=>
         mem_addr_o == $past(base_val_i) + {24'h00_0000, $past(instr_i[11:8]), $past(instr_i[3:0])};
   endproperty
   a_imm_up: assert property (p_imm_up) else $error("immediate up address wrong");

   // Register pre-indexed down address
   property p_reg_down;
      (go && !instr_i[BIT_IMM] && f_pre && !f_up) |=>
         mem_addr_o == $past(base_val_i) - $past(index_val_i);
   endproperty
   a_reg_down: assert property (p_reg_down) else $error("down address wrong");

   // Post-indexed uses plain base
   property p_post_addr;
      (go && !f_pre) |=> mem_addr_o == $past(base_val_i);
   endproperty
   a_post_addr: assert property (p_post_addr) else $error("post address not base");

   // Pre-indexed without write-back never writes base
   property p_pre_nowb;
      (go && f_pre && !f_wb) |=> ##1 !base_we_o;
   endproperty
   a_pre_nowb: assert property (p_pre_nowb) else $error("base written without write-back");

   // Post-indexed up writes base plus offset unless aborted
   property p_post_wb;
      (go && !f_pre && f_up) ##1 !mem_abort_i |=>
         base_we_o && base_data_o == $past(base_val_i, 2) + $past(offset, 2);
   endproperty
   a_post_wb: assert property (p_post_wb) else $error("post-index write-back missing");

   // Unsigned halfword has clear upper half
   property p_uhalf;
      (mem_req_o && !mem_abort_i && kind_q == KIND_LOAD_UHALF) |=>
         dest_we_o && dest_data_o[31:16] == 16'h0000;
   endproperty
   a_uhalf: assert property (p_uhalf) else $error("unsigned halfword not zero filled");

   // Signed byte sign extension, little-endian lanes
   property p_sbyte_le;
      (mem_req_o && kind_q == KIND_LOAD_SBYTE && !xfer_be_q) |=>
         dest_data_o == {{24{$past(mem_rdata_i[mem_addr_o[1:0]*8+7])}},
                         $past(mem_rdata_i[mem_addr_o[1:0]*8 +: 8])};
   endproperty
   a_sbyte_le: assert property (p_sbyte_le) else $error("little-endian signed byte wrong");

   // Signed halfword big-endian lane choice
   property p_shalf_be;
      (mem_req_o && kind_q == KIND_LOAD_SHALF && xfer_be_q) |=>
         dest_data_o == ($past(mem_addr_o[1]) ?
            {{16{$past(mem_rdata_i[15])}}, $past(mem_rdata_i[15:0])} :
            {{16{$past(mem_rdata_i[31])}}, $past(mem_rdata_i[31:16])});
   endproperty
   a_shalf_be: assert property (p_shalf_be) else $error("big-endian signed halfword wrong");

   // Store data replicated on both halves
   property p_store_rep;
      (mem_req_o && mem_write_o) |-> mem_wdata_o[31:16] == mem_wdata_o[15:0];
   endproperty
   a_store_rep: assert property (p_store_rep) else $error("store halves differ");

   // Abort suppresses register updates and raises trap
   property p_abort;
      (mem_req_o && mem_abort_i) |=> abort_trap_o && !dest_we_o && !base_we_o;
   endproperty
   a_abort: assert property (p_abort) else $error("abort altered registers");

   // Back-to-back issue, one request per cycle
   property p_single;
      go ##1 go |=> mem_req_o && $past(mem_req_o);
   endproperty
   a_single: assert property (p_single) else $error("transfer not single cycle");

   // Signed byte sign extension, big-endian lanes
   property p_sbyte_be;
      (mem_req_o && kind_q == KIND_LOAD_SBYTE && xfer_be_q) |=>
         dest_data_o == {{24{$past(mem_rdata_i[31 - mem_addr_o[1:0]*8])}},
                         $past(mem_rdata_i[(3 - mem_addr_o[1:0])*8 +: 8])};
   endproperty
   a_sbyte_be: assert property (p_sbyte_be) else $error("big-endian signed byte wrong");

   // Signed halfword little-endian lane choice
   property p_shalf_le;
      (mem_req_o && kind_q == KIND_LOAD_SHALF && !xfer_be_q) |=>
         dest_data_o == ($past(mem_addr_o[1]) ?
            {{16{$past(mem_rdata_i[31])}}, $past(mem_rdata_i[31:16])} :
            {{16{$past(mem_rdata_i[15])}}, $past(mem_rdata_i[15:0])});
   endproperty
   a_shalf_le: assert property (p_shalf_le) else $error("little-endian signed halfword wrong");

   // Unsigned halfword big-endian lane choice
   property p_uhalf_be;
      (mem_req_o && kind_q == KIND_LOAD_UHALF && xfer_be_q) |=>
         dest_data_o == {16'h0000, ($past(mem_addr_o[1]) ?
                                    $past(mem_rdata_i[15:0]) : $past(mem_rdata_i[31:16]))};
   endproperty
   a_uhalf_be: assert property (p_uhalf_be) else $error("big-endian unsigned halfword wrong");

   // Unsigned halfword little-endian lane choice
   property p_uhalf_le;
      (mem_req_o && kind_q == KIND_LOAD_UHALF && !xfer_be_q) |=>
         dest_data_o == {16'h0000, ($past(mem_addr_o[1]) ?
                                    $past(mem_rdata_i[31:16]) : $past(mem_rdata_i[15:0]))};
   endproperty
   a_uhalf_le: assert property (p_uhalf_le) else $error("little-endian unsigned halfword wrong");

   // Store data is the low source half twice
   property p_store_data;
      (go && !f_load) |=> mem_write_o && mem_wdata_o == {2{$past(store_val_i[15:0])}};
   endproperty
   a_store_data: assert property (p_store_data) else $error("store data not replicated source");

   // Pre-indexed write-back stores the transfer address as new base
   property p_pre_wb;
      (go && f_pre && f_wb) ##1 !mem_abort_i |=>
         base_we_o && base_data_o == $past(mem_addr_o);
   endproperty
   a_pre_wb: assert property (p_pre_wb) else $error("pre-index write-back wrong");

   // Post-indexed down writes base minus offset
   property p_post_down_wb;
      (go && !f_pre && !f_up) ##1 !mem_abort_i |=>
         base_we_o && base_data_o == $past(base_val_i, 2) - $past(offset, 2);
   endproperty
   a_post_down_wb: assert property (p_post_down_wb) else $error("post-index down write-back wrong");

   // Endian level holds while the last two flops disagree
   property p_be_hold;
      (be_sync_q[2] != be_sync_q[1]) |=> $stable(be_q);
   endproperty
   a_be_hold: assert property (p_be_hold) else $error("endian level moved before settling");

   // Endian level follows once the last two flops agree
   property p_be_take;
      (be_sync_q[2] == be_sync_q[1]) |=> be_q == $past(be_sync_q[2]);
   endproperty
   a_be_take: assert property (p_be_take) else $error("endian level not taken");

   // Signed encodings with the load bit clear are dropped
   property p_signed_store_drop;
      (issue_i && instr_i[BIT_SIGNED] && !instr_i[BIT_LOAD]) |=> !mem_req_o;
   endproperty
   a_signed_store_drop: assert property (p_signed_store_drop) else $error("signed store issued");

   // A store never writes the destination
   property p_store_nodest;
      (mem_req_o && mem_write_o) |=> !dest_we_o;
   endproperty
   a_store_nodest: assert property (p_store_nodest) else $error("store wrote destination");

   // A clean load completes in the next cycle
   property p_load_done;
      (mem_req_o && !mem_write_o && !mem_abort_i) |=> dest_we_o;
   endproperty
   a_load_done: assert property (p_load_done) else $error("load did not complete");

   // Scenarios
   c_sbyte_be: cover property (mem_req_o && kind_q == KIND_LOAD_SBYTE && xfer_be_q);
   c_store:    cover property (mem_req_o && mem_write_o ##1 base_we_o);
   c_abort:    cover property (mem_req_o && mem_abort_i ##1 abort_trap_o);
   c_post:     cover property (go && !f_pre ##2 base_we_o);

endmodule

// *** design/hw_ls_pkg.sv ***
// Constants and types for the halfword and signed transfer datapath.
// Assumes a 32-bit core with the condition already evaluated upstream.
package hw_ls_pkg;
   localparam int DATA_W     = 32;
   localparam int OFFSET_W   = 8;
   localparam int HALF_W     = 16;
   localparam int BYTE_W     = 8;
   // Instruction field positions
   localparam int BIT_PRE    = 24;
   localparam int BIT_UP     = 23;
   localparam int BIT_IMM    = 22;
   localparam int BIT_WB     = 21;
   localparam int BIT_LOAD   = 20;
   localparam int BIT_SIGNED = 6;
   localparam int BIT_HALF   = 5;
   localparam int BIT_MARK_HI = 7;
   localparam int BIT_MARK_LO = 4;
   localparam int CLASS_MSB  = 27;
   localparam int CLASS_LSB  = 25;
   localparam int IMM_HI_MSB = 11;
   localparam int IMM_HI_LSB = 8;
   localparam int IMM_LO_MSB = 3;
   localparam int IMM_LO_LSB = 0;
   localparam logic [2:0] CLASS_CODE = 3'h0;
   // Reset values, offset padding and sync depth
   localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
   localparam logic [23:0] OFFSET_PAD = 24'h00_0000;
   localparam logic        BE_RESET  = 1'b0;
   localparam int SYNC_STAGES = 3;
   // Transfer kinds
   typedef enum logic [2:0] {
      KIND_NONE,
      KIND_STORE_HALF,
      KIND_LOAD_UHALF,
      KIND_LOAD_SBYTE,
      KIND_LOAD_SHALF
   } xfer_kind_type;
endpackage

// *** tb/mem_model.sv ***
// Memory-side partner for the halfword and signed transfer datapath.
// Assumes one-cycle requests; read word and abort are chosen by the bench.
`timescale 1ns/1ps

module mem_model (
   input  wire logic        core_clk_i,
   input  wire logic        mem_req_i,
   input  wire logic        mem_write_i,
   input  wire logic [31:0] mem_addr_i,
   input  wire logic [31:0] mem_wdata_i,
   input  wire logic        big_endian_i,
   input  wire logic [31:0] word_i,
   input  wire logic        abort_i,
   output logic      [31:0] rdata_o,
   output logic             abort_o,
   output logic      [31:0] stored_o
);
   logic [31:0] last_q = 32'h0000_0000;
   logic [31:0] store_q = 32'h0000_0000;

   // Stored word starts known so both halves compare
   assign stored_o = store_q;

   // Released bus shows the inverse of the last word, never a stale copy
   assign rdata_o = mem_req_i ? word_i : ~last_q;
   assign abort_o = mem_req_i & abort_i;

   // One stored word, only the addressed halfword is written
   always @(posedge core_clk_i) begin
      if (mem_req_i) begin
         last_q <= word_i;
      end
      if (mem_req_i & mem_write_i) begin
         if (mem_addr_i[1] ^ big_endian_i) begin
            store_q[31:16] <= mem_wdata_i[31:16];
         end else begin
            store_q[15:0] <= mem_wdata_i[15:0];
         end
      end
   end
endmodule

// *** tb/tb.sv ***
// Self-checking bench for the halfword and signed transfer datapath.
// Assumes the memory partner mem_model and a 10 MHz core clock.
`timescale 1ns/1ps

module tb;
   logic        core_clk_i = 1'b0;
   logic        resetn_i = 1'b0;
   logic        issue_i = 1'b0;
   logic        cond_pass_i = 1'b0;
   logic        big_endian_select_i = 1'b0;
   logic        abort_q = 1'b0;
   logic        be = 1'b0;
   logic [31:0] instr_i = 32'h0000_0000;
   logic [31:0] base_val_i = 32'h0000_0000;
   logic [31:0] index_val_i = 32'h0000_0000;
   logic [31:0] store_val_i = 32'h0000_0000;
   logic [31:0] word_q = 32'h0000_0000;
   logic [31:0] exp_store = 32'h0000_0000;
   logic [31:0] mem_rdata_i, mem_addr_o, mem_wdata_o, dest_data_o, base_data_o, stored_o;
   logic        mem_abort_i, mem_req_o, mem_write_o, dest_we_o, base_we_o, abort_trap_o;
   int          mismatches = 0;
   int          samples_checked = 0;

   // Core clock, 100 ns period
   always #50 core_clk_i = ~core_clk_i;

   halfword_signed_load_store u_halfword_signed_load_store (.core_clk_i, .resetn_i, .issue_i, .instr_i,
      .cond_pass_i, .base_val_i, .index_val_i, .store_val_i, .big_endian_select_i, .mem_rdata_i,
      .mem_abort_i, .mem_req_o, .mem_write_o, .mem_addr_o, .mem_wdata_o, .dest_we_o, .dest_data_o,
      .base_we_o, .base_data_o, .abort_trap_o);

   mem_model u_mem_model (.core_clk_i, .mem_req_i(mem_req_o), .mem_write_i(mem_write_o),
      .mem_addr_i(mem_addr_o), .mem_wdata_i(mem_wdata_o), .big_endian_i(be), .word_i(word_q),
      .abort_i(abort_q), .rdata_o(mem_rdata_i), .abort_o(mem_abort_i), .stored_o(stored_o));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         mismatches++;
         $display("FAIL %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic print_verdict();
      if (mismatches == 0 && samples_checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // Halfword or signed transfer word, register form uses index in bits 3:0
   function automatic logic [31:0] enc(logic p, u, i, w, l, s, h, logic [7:0] off);
      return {4'hE, 3'h0, p, u, i, w, l, 4'h2, 4'h1, i ? off[7:4] : 4'h0, 1'b1, s, h, 1'b1,
              i ? off[3:0] : 4'h3};
   endfunction

   // Expected destination value for a load
   function automatic logic [31:0] lane(logic [31:0] wd, logic [1:0] a, logic s, logic h);
      logic [7:0]  b;
      logic [15:0] hw;
      b = 8'(wd >> (8 * (be ? 3 - a : a)));
      hw = 16'(wd >> (16 * (be ? !a[1] : a[1])));
      if (!h) return {{24{b[7]}}, b};
      if (s) return {{16{hw[15]}}, hw};
      return {16'h0000, hw};
   endfunction

   task automatic set_be(input logic v);
      @(posedge core_clk_i);
      big_endian_select_i <= v;
      be <= v;
      repeat (4) @(posedge core_clk_i);
   endtask

   // One instruction, judged at the request cycle and the result cycle
   task automatic run(input logic [31:0] ins, input logic [31:0] base, input logic [31:0] src,
                      input logic cnd, input logic [31:0] wd, input logic abt);
      logic [31:0] off, md, ad;
      logic        act, wb, ld;
      off = ins[22] ? {24'h00_0000, ins[11:8], ins[3:0]} : 32'h0000_0024;
      md = ins[23] ? base + off : base - off;
      ad = ins[24] ? md : base;
      wb = !ins[24] || ins[21];
      ld = ins[20];
      act = cnd && ins[27:25] == 3'h0 && ins[7] && ins[4] && ins[6:5] != 2'h0 && !(ins[6] && !ld);
      @(posedge core_clk_i);
      issue_i <= 1'b1;
      instr_i <= ins;
      base_val_i <= base;
      index_val_i <= 32'h0000_0024;
      store_val_i <= src;
      cond_pass_i <= cnd;
      word_q <= wd;
      abort_q <= abt;
      @(posedge core_clk_i);
      issue_i <= 1'b0;
      #1;
      chk(32'(mem_req_o), 32'(act));
      if (act) begin
         chk(mem_addr_o, ad);
         chk(32'(mem_write_o), 32'(!ld));
         if (!ld) chk(mem_wdata_o, {src[15:0], src[15:0]});
      end
      @(posedge core_clk_i);
      #1;
      chk(32'(dest_we_o), 32'(act && ld && !abt));
      chk(32'(base_we_o), 32'(act && wb && !abt));
      chk(32'(abort_trap_o), 32'(act && abt));
      if (dest_we_o === 1'b1) chk(dest_data_o, lane(wd, ad[1:0], ins[6], ins[5]));
      if (base_we_o === 1'b1) chk(base_data_o, md);
   endtask

   // Every pre, post, up, down and write-back mix except post with the write-back bit set, immediate and register
   task automatic t_index();
      for (int k = 0; k < 16; k++) begin
         if (k[3] || !k[0]) begin
            run(enc(k[3], k[2], k[1], k[0], 1'b1, 1'b0, 1'b1, 8'hA6), 32'h0000_1000, 0, 1, 32'h8A7F_13C6, 0);
         end
      end
   endtask

   // Byte and halfword lanes in both endian settings
   task automatic t_lanes();
      for (int e = 0; e < 2; e++) begin
         set_be(e[0]);
         for (int a = 0; a < 4; a++) begin
            run(enc(1, 1, 1, 0, 1, 1, 0, 8'(a)), 32'h0000_2000, 0, 1, 32'h8A7F_13C6, 0);
            run(enc(1, 1, 1, 0, 1, a[0], 1, 8'(a & 2)), 32'h0000_2000, 0, 1, 32'h8A7F_13C6, 0);
         end
      end
   endtask

   // Halfword stores land only in the addressed half
   task automatic t_store();
      for (int k = 0; k < 4; k++) begin
         set_be(k[1]);
         run(enc(1, 1, 1, 0, 0, 0, 1, 8'(k[0] * 2)), 32'h0000_4000, 32'hDEAD_5A3C + k, 1, 0, 0);
         if (k[0] ^ k[1]) exp_store[31:16] = 16'h5A3C + 16'(k);
         else exp_store[15:0] = 16'h5A3C + 16'(k);
         chk(stored_o, exp_store);
      end
   endtask

   // Failed condition, signed store, foreign encoding and aborts
   task automatic t_refuse();
      run(enc(1, 1, 1, 1, 1, 0, 1, 8'h02), 32'h0000_1000, 0, 0, 0, 0);
      run(enc(1, 1, 1, 0, 0, 1, 1, 8'h02), 32'h0000_1000, 0, 1, 0, 0);
      run(enc(1, 1, 1, 0, 1, 0, 1, 8'h02) & 32'hFFFF_FFEF, 32'h0000_1000, 0, 1, 0, 0);
      run(enc(1, 1, 1, 1, 1, 1, 1, 8'h04), 32'h0000_1000, 0, 1, 32'h0000_8000, 1);
      run(enc(0, 0, 1, 0, 1, 0, 1, 8'h04), 32'h0000_1000, 0, 1, 32'h0000_8000, 1);
   endtask

   // Two loads issued on consecutive edges
   task automatic t_b2b();
      @(posedge core_clk_i);
      issue_i <= 1'b1;
      cond_pass_i <= 1'b1;
      abort_q <= 1'b0;
      instr_i <= enc(1, 1, 1, 0, 1, 0, 1, 8'h02);
      base_val_i <= 32'h0000_3000;
      word_q <= 32'h1234_5678;
      @(posedge core_clk_i);
      instr_i <= enc(1, 1, 1, 0, 1, 0, 1, 8'h00);
      #1 chk(mem_addr_o, 32'h0000_3002);
      @(posedge core_clk_i);
      issue_i <= 1'b0;
      #1 chk(mem_addr_o, 32'h0000_3000);
      chk(dest_data_o, 32'h0000_1234);
      @(posedge core_clk_i);
      #1 chk(32'({dest_we_o, mem_req_o}), 32'h0000_0002);
      chk(dest_data_o, 32'h0000_5678);
   endtask

   // Reset in mid-transfer clears every pulse output
   task automatic t_reset();
      @(posedge core_clk_i);
      issue_i <= 1'b1;
      instr_i <= enc(1, 1, 1, 1, 1, 0, 1, 8'h02);
      @(posedge core_clk_i);
      issue_i <= 1'b0;
      resetn_i <= 1'b0;
      #1 chk(32'({mem_req_o, dest_we_o, base_we_o, abort_trap_o}), 32'h0000_0000);
      repeat (3) @(posedge core_clk_i);
      resetn_i <= 1'b1;
      @(posedge core_clk_i);
      #1 chk(32'({mem_req_o, dest_we_o, base_we_o, abort_trap_o}), 32'h0000_0000);
   endtask

   // Reset, then the scenarios in turn
   initial begin
      repeat (3) @(posedge core_clk_i);
      resetn_i <= 1'b1;
      #1 chk(32'({mem_req_o, dest_we_o, base_we_o, abort_trap_o}), 32'h0000_0000);
      set_be(1'b0);
      t_index();
      t_refuse();
      t_b2b();
      t_reset();
      t_store();
      t_lanes();
      print_verdict();
   end

   // Watchdog against a hang
   initial begin
      #1_000_000;
      mismatches++;
      print_verdict();
   end
endmodule
